// ### pkg/fbp_pkg.sv
// constants for the flash block erase and protection gate
`default_nettype none
package fbp_pkg;
    localparam int ADDR_W = 16;            // 64 KB byte space
    localparam int FLASH_BYTES = 65536;
    localparam int UNIT_BYTES = 1024;      // erase unit
    localparam int REGION_BYTES = 2048;    // protection region
    localparam int UNIT_W = 10;            // byte offset bits in a unit
    localparam int REGION_SHIFT = 11;      // region index position
    localparam int NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
    localparam int NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
    localparam int DATA_W = 32;
    localparam int WORD_SHIFT = 2;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
    // protection setting per region
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_RO = 2'h1;
    localparam logic [1:0] PROT_XO = 2'h2;
    // request kinds
    typedef enum logic [4:0] {
        FBP_IDLE = 5'b00001,
        FBP_FETCH = 5'b00010,
        FBP_READ = 5'b00100,
        FBP_PROG = 5'b01000,
        FBP_ERASE = 5'b10000
    } fbp_op_t;
endpackage
`default_nettype wire

// ### hdl/fbp_region_check.sv
// per-region protection lookup for one address
`default_nettype none
module fbp_region_check
    import fbp_pkg::*;
#(
    parameter int REGIONS = NUM_REGIONS
) (
    input wire logic [2*REGIONS-1:0] prot,
    input wire logic [ADDR_W-1:0] addr,
    output logic is_ro,
    output logic is_xo
);
    logic [REGIONS-1:0] hit_ro;
    logic [REGIONS-1:0] hit_xo;
    // one decoder per region; index is the address above the 2 KB boundary
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++) begin : g_reg
            logic sel;
            assign sel = (addr[ADDR_W-1:REGION_SHIFT] == (ADDR_W-REGION_SHIFT)'(g));
            assign hit_ro[g] = sel && (prot[2*g+:2] == PROT_RO);
            assign hit_xo[g] = sel && (prot[2*g+:2] == PROT_XO);
        end
    endgenerate
    assign is_ro = |hit_ro;
    assign is_xo = |hit_xo;
endmodule
`default_nettype wire

// ### hdl/fbp_gate.sv
// flash access gate: erase units, protection regions, violation flag
// Overview of operation
// - the array is 64 KB and every address in it is decoded
// - erase acts on one 1 KB unit and leaves other units alone
// - an erased unit reads back as all ones
// - protection covers 2 KB regions, two erase units each, independently
// - each region is unprotected, read-only or execute-only
// - program or erase into a read-only region is refused, contents kept
// - program or erase into an execute-only region is refused, contents kept
// - execute-only regions serve instruction fetches, deny data and debug reads
`default_nettype none
module fbp_gate
    import fbp_pkg::*;
#(
    parameter int REGIONS = NUM_REGIONS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2*REGIONS-1:0] prot,
    input wire logic fetch_req,
    input wire logic read_req,
    input wire logic dbg_req,
    input wire logic prog_req,
    input wire logic erase_req,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic viol_clr,
    output logic ack,
    output logic denied,
    output logic [DATA_W-1:0] rdata,
    output logic viol
);
    localparam int WORDS = FLASH_BYTES >> WORD_SHIFT;
    localparam int WA_W = ADDR_W - WORD_SHIFT;
    localparam int UWORDS = UNIT_BYTES >> WORD_SHIFT;
    localparam int UW_W = UNIT_W - WORD_SHIFT;

    logic [DATA_W-1:0] mem [WORDS];
    logic is_ro;
    logic is_xo;
    logic ack_q, ack_d;
    logic denied_q, denied_d;
    logic viol_q, viol_d;
    // violation flag: set by the sequencer, cleared from outside
    logic set_viol;
    // protection verdicts for the captured address, and the take gate
    logic refuse_wr;
    logic refuse_rd;
    logic take_ok;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    fbp_op_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [UW_W-1:0] ecnt_q, ecnt_d;
    logic wr_en;
    logic [WA_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [WA_W-1:0] rd_addr;

    // lookup runs on the captured address, not on the live request lines
    fbp_region_check #(.REGIONS(REGIONS)) u_check (
        .prot(prot),
        .addr(addr_q),
        .is_ro(is_ro),
        .is_xo(is_xo)
    );

    // upper 14 bits of the 16-bit byte address select one of 16 K words
    assign rd_addr = addr_q[ADDR_W-1:WORD_SHIFT];

    // both protected kinds lock the array against change; only execute-only hides data
    assign refuse_wr = is_ro || is_xo;
    assign refuse_rd = is_xo;

    // no request is taken in the answer cycle: a requester may hold its line until it
    // sees ack, and the same access is still taken only once
    assign take_ok = !ack_q;

    // request capture and the access sequence; erase walks one unit word by word
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        ecnt_d = ecnt_q;
        ack_d = 1'b0;
        denied_d = 1'b0;
        rdata_d = rdata_q;
        set_viol = 1'b0;
        wr_en = 1'b0;
        wr_addr = rd_addr;
        wr_data = wdata_q;
        unique case (state_q)
            FBP_IDLE: begin
                // address and data follow the bus while idle; the taking edge freezes them
                addr_d = addr;
                wdata_d = wdata;
                ecnt_d = '0;
                // priority: erase, program, fetch, then data or debug read alike
                if (!take_ok) begin
                    state_d = FBP_IDLE;
                end else if (erase_req) begin
                    state_d = FBP_ERASE;
                end else if (prog_req) begin
                    state_d = FBP_PROG;
                end else if (fetch_req) begin
                    state_d = FBP_FETCH;
                end else if (read_req || dbg_req) begin
                    state_d = FBP_READ;
                end
            end
            FBP_FETCH: begin
                // fetches are never refused; execute-only regions exist for them
                rdata_d = mem[rd_addr];
                ack_d = 1'b1;
                state_d = FBP_IDLE;
            end
            FBP_READ: begin
                ack_d = 1'b1;
                state_d = FBP_IDLE;
                // a debug read is a data read; only the fetch path may see these words
                if (refuse_rd) begin
                    rdata_d = '0;
                    denied_d = 1'b1;
                    set_viol = 1'b1;
                end else begin
                    rdata_d = mem[rd_addr];
                end
            end
            FBP_PROG: begin
                ack_d = 1'b1;
                state_d = FBP_IDLE;
                // a refused program leaves the word alone and answers at once
                if (refuse_wr) begin
                    denied_d = 1'b1;
                    set_viol = 1'b1;
                end else begin
                    // flash programming only clears bits
                    wr_en = 1'b1;
                    wr_data = mem[rd_addr] & wdata_q;
                end
            end
            FBP_ERASE: begin
                // checked every word, so a region locked mid-walk stops the erase there
                if (refuse_wr) begin
                    denied_d = 1'b1;
                    set_viol = 1'b1;
                    ack_d = 1'b1;
                    state_d = FBP_IDLE;
                end else begin
                    wr_en = 1'b1;
                    // one word per cycle; the unit bits stay fixed while the offset counts
                    wr_addr = {addr_q[ADDR_W-1:UNIT_W], ecnt_q};
                    wr_data = ERASED_WORD;
                    ecnt_d = ecnt_q + 1'b1;
                    if (ecnt_q == UW_W'(UWORDS - 1)) begin
                        ack_d = 1'b1;
                        state_d = FBP_IDLE;
                    end
                end
            end
            default: begin
                state_d = FBP_IDLE;
            end
        endcase
    end

    // sequencer and answer registers; the array and the violation flag
    // have processes of their own below
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= FBP_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            ecnt_q <= '0;
            ack_q <= 1'b0;
            denied_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            ecnt_q <= ecnt_d;
            ack_q <= ack_d;
            denied_q <= denied_d;
            rdata_q <= rdata_d;
        end
    end

    // array write port; held off during reset so an unknown state cannot write;
    // the array has no reset value, like real flash, and must be erased before use
    always_ff @(posedge clk) begin
        if (wr_en && !rst) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // violation flag: a refusal in the clear cycle wins, so no refusal goes unseen
    always_comb begin
        viol_d = viol_q;
        if (set_viol) begin
            viol_d = 1'b1;
        end else if (viol_clr) begin
            viol_d = 1'b0;
        end
    end

    // sticky until cleared; reset is the only other way out
    always_ff @(posedge clk) begin
        if (rst) begin
            viol_q <= 1'b0;
        end else begin
            viol_q <= viol_d;
        end
    end

    assign ack = ack_q;
    assign denied = denied_q;
    assign rdata = rdata_q;
    assign viol = viol_q;
endmodule
`default_nettype wire

// ### testbench/fbp_gate_props.sv
// port assertions for the flash access gate
`default_nettype none
module fbp_gate_props
    import fbp_pkg::*;
#(
    parameter int REGIONS = NUM_REGIONS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic viol_clr,
    input wire logic ack,
    input wire logic denied,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic viol
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ack_one_cycle_a: assert property (ack |=> !ack) else $error("ack too long");
    deny_with_ack_a: assert property (denied |-> ack) else $error("lone denied");
    viol_on_deny_a: assert property (denied |-> ##[0:1] viol) else $error("viol not set");
    viol_sticky_a: assert property (viol && !viol_clr |=> viol) else $error("viol lost");
    viol_clears_a: assert property (viol_clr && !ack |=> !viol || denied)
        else $error("viol not cleared");
    viol_cause_a: assert property ($rose(viol) |-> denied || $past(denied))
        else $error("viol without refusal");
    deny_no_data_a: assert property (denied |-> rdata == '0 || $stable(rdata))
        else $error("denied read leaked data");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !ack && !viol && rdata == '0)
        else $error("outputs live in reset");
    cover property (ack && !denied);
    cover property (denied);
    cover property (viol && viol_clr);
endmodule
bind fbp_gate fbp_gate_props #(.REGIONS(REGIONS)) u_props (.clk(clk), .rst(rst),
    .viol_clr(viol_clr), .ack(ack), .denied(denied), .rdata(rdata), .viol(viol));
`default_nettype wire

// ### testbench/fbp_host.sv
// requester model: fetch, data read, debug read, program and erase
`default_nettype none
module fbp_host
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic ack,
    output logic fetch_req = 1'b0,
    output logic read_req = 1'b0,
    output logic dbg_req = 1'b0,
    output logic prog_req = 1'b0,
    output logic erase_req = 1'b0,
    output logic [ADDR_W-1:0] addr = '0,
    output logic [DATA_W-1:0] wdata = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    // request, address and data stand until ack is seen high, then all drop at that
    // edge; released lines show the inverse so stale values cannot pass
    task automatic access(input fbp_op_t op, input logic dbg, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk);
        fetch_req <= op[1];
        read_req <= op[2] & ~dbg;
        dbg_req <= op[2] & dbg;
        prog_req <= op[3];
        erase_req <= op[4];
        addr <= a;
        wdata <= d;
        // an erase answers after 257 cycles; the bound only guards against a hang
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                break;
            end
        end
        {fetch_req, read_req, dbg_req, prog_req, erase_req} <= '0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### testbench/flash_block_erase_protect_test.sv
// self-checking bench for the flash access gate
`default_nettype none
module flash_block_erase_protect_test
    import fbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic viol_clr = 1'b0;
    logic [2*NUM_REGIONS-1:0] prot = '0;
    logic fetch_req, read_req, dbg_req, prog_req, erase_req, ack, denied, viol;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [33:0] notes[$];
    int fails = 0;
    int n_checks = 0;
    fbp_host host (
        .clk(clk),
        .ack(ack),
        .fetch_req(fetch_req),
        .read_req(read_req),
        .dbg_req(dbg_req),
        .prog_req(prog_req),
        .erase_req(erase_req),
        .addr(addr),
        .wdata(wdata)
    );
    fbp_gate dut (
        .clk(clk),
        .rst(rst),
        .prot(prot),
        .fetch_req(fetch_req),
        .read_req(read_req),
        .dbg_req(dbg_req),
        .prog_req(prog_req),
        .erase_req(erase_req),
        .addr(addr),
        .wdata(wdata),
        .viol_clr(viol_clr),
        .ack(ack),
        .denied(denied),
        .rdata(rdata),
        .viol(viol)
    );
    initial forever #50 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // note the expected answer, then issue; rdata only matters for reads
    task automatic go(input fbp_op_t op, input logic dbg, input logic [15:0] a,
                      input logic [31:0] d, input logic den, input logic [31:0] exp);
        notes.push_back({op inside {FBP_FETCH, FBP_READ}, den, exp});
        host.access(op, dbg, a, d);
    endtask
    // compare each answer against the oldest note
    always @(posedge clk) begin
        logic [33:0] e;
        if (ack === 1'b1) begin
            check(32'(notes.size() != 0), 32'h1);
            e = notes.pop_front();
            check({31'h0, denied}, {31'h0, e[32]});
            if (e[33]) check(rdata, e[31:0]);
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(96));
        r = $urandom;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        go(FBP_ERASE, 1'b0, 16'h0000, '0, 1'b0, '0);
        go(FBP_ERASE, 1'b0, 16'hfc00, '0, 1'b0, '0);
        go(FBP_READ, 1'b0, 16'hfffc, '0, 1'b0, ERASED_WORD);
        go(FBP_PROG, 1'b0, 16'h0004, r, 1'b0, '0);
        go(FBP_READ, 1'b0, 16'h0004, '0, 1'b0, r);
        go(FBP_ERASE, 1'b0, 16'h0400, '0, 1'b0, '0);
        go(FBP_READ, 1'b0, 16'h0004, '0, 1'b0, r);
        go(FBP_READ, 1'b1, 16'h0400, '0, 1'b0, ERASED_WORD);
        prot <= {PROT_RO, 62'h0};
        go(FBP_PROG, 1'b0, 16'h0008, '0, 1'b0, '0);
        go(FBP_READ, 1'b0, 16'h0008, '0, 1'b0, '0);
        go(FBP_PROG, 1'b0, 16'hfffc, '0, 1'b1, '0);
        go(FBP_ERASE, 1'b0, 16'hf800, '0, 1'b1, '0);
        go(FBP_READ, 1'b0, 16'hfffc, '0, 1'b0, ERASED_WORD);
        prot <= {62'h0, PROT_XO};
        go(FBP_READ, 1'b0, 16'h0004, '0, 1'b1, '0);
        go(FBP_READ, 1'b1, 16'h0004, '0, 1'b1, '0);
        go(FBP_ERASE, 1'b0, 16'h0000, '0, 1'b1, '0);
        go(FBP_FETCH, 1'b0, 16'h0004, '0, 1'b0, r);
        check({31'h0, viol}, 32'h1);
        viol_clr <= 1'b1;
        @(posedge clk);
        viol_clr <= 1'b0;
        @(posedge clk);
        check({31'h0, viol}, 32'h0);
        prot <= 64'h3;
        go(FBP_PROG, 1'b0, 16'h0004, '0, 1'b0, '0);
        go(FBP_READ, 1'b0, 16'h0004, '0, 1'b0, '0);
        // let the watcher take the last answer before the queue is judged
        @(posedge clk);
        check(32'(notes.size()), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
